// File: pkg/uv_balance_pkg.sv
// constants and types for the balancing measurement controller
package uv_balance_pkg;
    localparam int unsigned NUM_CELLS      = 14;
    localparam int unsigned THR_W          = 14;
    localparam int unsigned THR_LSB_UV     = 305;
    // register word offsets
    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_THR        = 4'h1;
    localparam logic [3:0] ADDR_UVSTAT     = 4'h2;
    localparam logic [3:0] ADDR_SWEN       = 4'h3;
    localparam logic [3:0] ADDR_CELLCFG    = 4'h4;
    localparam logic [3:0] ADDR_SCAN       = 4'h5;
    localparam logic [3:0] ADDR_DLY        = 4'h6;
    localparam logic [3:0] ADDR_STATUS     = 4'h7;
    // register fields, codes and other constants
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_MEAS_LSB  = 4;
    localparam int unsigned CTRL_INIT_BIT  = 6;
    localparam int unsigned CTRL_CAL_BIT   = 7;
    localparam int unsigned THR_MIN_BIT    = 15;
    localparam int unsigned CELLCFG_POL_LSB = 16;
    localparam int unsigned SCAN_FC_LSB    = 8;
    localparam logic [2:0] MODE_OFF        = 3'h0;
    localparam logic [2:0] MODE_DISCHARGE  = 3'h3;
    localparam logic [1:0] MEAS_CHECK      = 2'h3;
    localparam logic [2:0] FC_BYPASS       = 3'h7;
    localparam logic [2:0] FC_EIGHTH       = 3'h0;
    localparam logic [1:0] OVS_16X         = 2'h2;
    localparam logic [1:0] SCAN_PYRAMID    = 2'h1;
    localparam logic [4:0] SETTLE_SAMPLES  = 5'h10;
    localparam logic [13:0] THR_RESET      = 14'h0000;
    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_BUSY} phase_t;
    // calibration interval in measurement cycles
    function automatic logic [5:0] cal_period(input logic [2:0] code);
        unique case (code)
            3'h1: cal_period = 6'h02;
            3'h2: cal_period = 6'h04;
            3'h3: cal_period = 6'h08;
            3'h4: cal_period = 6'h0C;
            3'h5: cal_period = 6'h10;
            3'h6: cal_period = 6'h18;
            3'h7: cal_period = 6'h20;
            default: cal_period = 6'h00;
        endcase
    endfunction
endpackage

// File: core/cell_result_mem.sv
`timescale 1ns/1ps
// per-cell word memory with registered read data
module cell_result_mem
    import uv_balance_pkg::*;
#(
    parameter int unsigned DEPTH = 14,
    parameter int unsigned WIDTH = 14
) (
    // clock
    input  wire logic                     clk_in,
    input  wire logic                     ce_in,
    // write port
    input  wire logic                     we_in,
    input  wire logic [3:0]               waddr_in,
    input  wire logic [WIDTH-1:0]         wdata_in,
    // read port
    input  wire logic [3:0]               raddr_in,
    output logic      [WIDTH-1:0]         rdata_out
);
    logic [WIDTH-1:0] mem [DEPTH];
    if (DEPTH < 1 || DEPTH > 16) begin : g_depth_check
        $error("depth outside address range");
    end
    // storage write
    always_ff @(posedge clk_in) begin
        if (ce_in && we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end
    // registered read
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule // cell_result_mem

// File: core/iir_cell_filter.sv
`timescale 1ns/1ps
// one-step IIR update for a cell accumulator
module iir_cell_filter
    import uv_balance_pkg::*;
#(
    parameter int unsigned WIDTH = 14
) (
    // operands
    input  wire logic [WIDTH-1:0] acc_in,
    input  wire logic [WIDTH-1:0] sample_in,
    input  wire logic [2:0]       coeff_in,
    input  wire logic             init_in,
    // result
    output logic      [WIDTH-1:0] acc_out
);
    logic [2:0]        eff;
    logic [WIDTH+3:0]  mix;
    // bypass code replaced by one eighth, weight (eff+1)/8
    always_comb begin
        eff = (coeff_in == FC_BYPASS) ? FC_EIGHTH : coeff_in;
        mix = (WIDTH+4)'(({1'b0, eff} + 4'h1) * sample_in)
            + (WIDTH+4)'((4'h7 - {1'b0, eff}) * acc_in);
        acc_out = init_in ? sample_in : mix[WIDTH+2:3];
    end
endmodule // iir_cell_filter

// File: core/cell_balance_uv_measure_ctrl.sv
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// balancing measurement, threshold exit and calibration scheduler
module cell_balance_uv_measure_ctrl
    import uv_balance_pkg::*;
#(
    parameter int unsigned CELLS = NUM_CELLS
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 ce_in,
    // register port
    input  wire logic [3:0]           addr_in,
    input  wire logic [31:0]          wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [31:0]          rdata_out,
    // balancing timing from the switch sequencer
    input  wire logic                 pair_done_in,
    input  wire logic                 timer_running_in,
    // adc engine
    output logic                      adc_start_out,
    output logic                      cal_start_out,
    output logic      [1:0]           oversample_count_out,
    output logic      [1:0]           scan_order_mode_out,
    output logic                      use_fresh_cal_out,
    output logic                      use_factory_cal_out,
    input  wire logic                 adc_done_in,
    input  wire logic [3:0]           adc_cell_in,
    input  wire logic [THR_W-1:0]     adc_data_in,
    input  wire logic [3:0]           lowest_cell_index_in,
    // switch and alert outputs
    output logic      [CELLS-1:0]     switch_on_out,
    output logic                      rejected_write_alert_out,
    output logic                      all_cells_done_out
);
    if (CELLS < 1 || CELLS > 16) begin : g_cells_check
        $error("cell count unsupported");
    end

    logic [31:0]        ctrl_r;
    logic [THR_W-1:0]   uv_threshold_r;
    logic               threshold_from_lowest_cell_r;
    logic [CELLS-1:0]   uv_exit_status_r;
    logic [CELLS-1:0]   balance_switch_enable_r;
    logic [CELLS-1:0]   cell_measure_enable_r;
    logic [CELLS-1:0]   polarity_r;
    logic [31:0]        scan_control_r;
    logic [2:0]         calibration_interval_r;
    logic               rejected_write_alert_r;
    logic [31:0]        rdata_r;
    logic [4:0]         settle_cnt_r;
    logic [5:0]         cycle_cnt_r;
    logic               started_r;
    logic               lowest_pending_r;
    phase_t             phase_r;
    logic               cal_cycle_r;
    logic               lowest_load_r;
    logic               sample_done_r;
    logic [3:0]         sample_cell_r;
    logic [THR_W-1:0]   sample_data_r;

    logic [2:0]         balance_mode_select;
    logic [1:0]         balance_measure_enable;
    logic               filter_init_on_entry;
    logic               apply_calibration;
    logic               active;
    logic               automated;
    logic               measuring;
    logic               checking;
    logic               mode_write;
    logic [CELLS-1:0]   checkable;
    logic [THR_W-1:0]   acc_rd;
    logic [THR_W-1:0]   acc_new;
    logic               acc_we;
    logic [3:0]         mem_raddr;
    logic [5:0]         period;

    assign balance_mode_select   = ctrl_r[CTRL_MODE_LSB +: 3];
    assign balance_measure_enable = ctrl_r[CTRL_MEAS_LSB +: 2];
    assign filter_init_on_entry  = ctrl_r[CTRL_INIT_BIT];
    assign apply_calibration     = ctrl_r[CTRL_CAL_BIT];
    assign active    = (balance_mode_select != MODE_OFF) && timer_running_in;
    // field drives measurement only in discharge and automated modes
    assign automated = active && (balance_mode_select >= MODE_DISCHARGE);
    assign measuring = automated && balance_measure_enable[1];
    assign checking  = measuring && (balance_measure_enable == MEAS_CHECK)
                     && (balance_mode_select != MODE_DISCHARGE);
    assign mode_write = ce_in && wr_in && (addr_in == ADDR_CTRL);
    assign checkable = balance_switch_enable_r & cell_measure_enable_r & ~polarity_r;
    assign period    = cal_period(calibration_interval_r);

    // forced acquisition parameters while measuring during balancing
    assign oversample_count_out = measuring ? OVS_16X : scan_control_r[1:0];
    assign scan_order_mode_out  = measuring ? SCAN_PYRAMID : scan_control_r[3:2];
    // calibration coefficient source
    assign use_fresh_cal_out   = apply_calibration && (calibration_interval_r != 3'h0)
                               && balance_measure_enable[1];
    assign use_factory_cal_out = !apply_calibration;
    assign adc_start_out = (phase_r == PH_WAIT) && !cal_cycle_r;
    assign cal_start_out = (phase_r == PH_WAIT) && cal_cycle_r;
    assign rejected_write_alert_out = rejected_write_alert_r;
    assign all_cells_done_out = checking && ((uv_exit_status_r | ~balance_switch_enable_r) == '1);

    // exit cells and all-done gate the switches
    always_comb begin
        switch_on_out = '0;
        if (active && !all_cells_done_out) begin
            switch_on_out = balance_switch_enable_r & ~uv_exit_status_r;
        end
    end

    // control register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= 32'h0000_0000;
        end else if (mode_write) begin
            ctrl_r <= {24'h00_0000, wdata_in[7:0]};
        end
    end

    // threshold and its source, lowest-cell word taken two cycles after the write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            uv_threshold_r <= THR_RESET;
            threshold_from_lowest_cell_r <= 1'b0;
            lowest_pending_r <= 1'b0;
            lowest_load_r <= 1'b0;
        end else if (ce_in) begin
            if (wr_in && addr_in == ADDR_THR) begin
                threshold_from_lowest_cell_r <= wdata_in[THR_MIN_BIT];
                lowest_pending_r <= wdata_in[THR_MIN_BIT];
                lowest_load_r <= 1'b0;
                if (!wdata_in[THR_MIN_BIT]) begin
                    uv_threshold_r <= wdata_in[THR_W-1:0];
                end
            end else begin
                // first cycle addresses the memory, second takes its registered output
                lowest_pending_r <= 1'b0;
                lowest_load_r <= lowest_pending_r;
                if (lowest_load_r) begin
                    uv_threshold_r <= acc_rd;
                end
            end
        end
    end

    // configuration registers, scan writes locked while balancing
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            balance_switch_enable_r <= '0;
            cell_measure_enable_r   <= '0;
            polarity_r              <= '0;
            scan_control_r          <= 32'h0000_0000;
            calibration_interval_r  <= 3'h0;
            rejected_write_alert_r  <= 1'b0;
        end else if (ce_in && wr_in) begin
            unique case (addr_in)
                ADDR_SWEN:    balance_switch_enable_r <= wdata_in[CELLS-1:0];
                ADDR_CELLCFG: begin
                    cell_measure_enable_r <= wdata_in[CELLS-1:0];
                    polarity_r <= wdata_in[CELLCFG_POL_LSB +: CELLS];
                end
                ADDR_SCAN: begin
                    if (active) begin
                        rejected_write_alert_r <= 1'b1;
                    end else begin
                        scan_control_r <= wdata_in;
                    end
                end
                ADDR_DLY:     calibration_interval_r <= wdata_in[2:0];
                ADDR_STATUS:  rejected_write_alert_r <= rejected_write_alert_r & ~wdata_in[0];
                default: ;
            endcase
        end
    end

    // entry detection for the exit flags
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            started_r <= 1'b0;
        end else if (ce_in) begin
            started_r <= mode_write ? 1'b0 : 1'b1;
        end
    end

    // measurement sequencer after each even odd pair
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_r <= PH_IDLE;
            cal_cycle_r <= 1'b0;
            cycle_cnt_r <= 6'h00;
        end else if (ce_in) begin
            if (mode_write || !measuring) begin
                phase_r <= PH_IDLE;
                cycle_cnt_r <= 6'h00;
                cal_cycle_r <= 1'b0;
            end else begin
                unique case (phase_r)
                    PH_IDLE: if (pair_done_in) begin
                        phase_r <= PH_WAIT;
                        // calibration replaces first and every period-th
                        cal_cycle_r <= (period != 6'h00) && (cycle_cnt_r == 6'h00);
                        cycle_cnt_r <= (period == 6'h00 || cycle_cnt_r + 6'h01 >= period)
                                       ? 6'h00 : cycle_cnt_r + 6'h01;
                    end
                    PH_WAIT: phase_r <= PH_BUSY;
                    PH_BUSY: if (adc_done_in) phase_r <= PH_IDLE;
                endcase
            end
        end
    end

    // adc result held one cycle while the accumulator of its own cell is read
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_done_r <= 1'b0;
            sample_cell_r <= 4'h0;
            sample_data_r <= '0;
        end else if (ce_in) begin
            sample_done_r <= (phase_r == PH_BUSY) && adc_done_in && !cal_cycle_r && measuring && !mode_write;
            sample_cell_r <= adc_cell_in;
            sample_data_r <= adc_data_in;
        end
    end

    // filter accumulators
    assign mem_raddr = lowest_pending_r ? lowest_cell_index_in : adc_cell_in;
    assign acc_we = sample_done_r && ce_in;
    iir_cell_filter #(.WIDTH(THR_W)) u_filter (
        .acc_in   (acc_rd),
        .sample_in(sample_data_r),
        .coeff_in (scan_control_r[SCAN_FC_LSB +: 3]),
        .init_in  (filter_init_on_entry && settle_cnt_r == 5'h00),
        .acc_out  (acc_new)
    );
    cell_result_mem #(.DEPTH(CELLS), .WIDTH(THR_W)) u_mem (
        .clk_in   (clk_in),
        .ce_in    (ce_in),
        .we_in    (acc_we),
        .waddr_in (sample_cell_r),
        .wdata_in (acc_new),
        .raddr_in (mem_raddr),
        .rdata_out(acc_rd)
    );

    // settling count of samples after initialisation
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_cnt_r <= 5'h00;
        end else if (ce_in) begin
            if (mode_write) begin
                settle_cnt_r <= 5'h00;
            end else if (acc_we && settle_cnt_r <= SETTLE_SAMPLES) begin
                settle_cnt_r <= settle_cnt_r + 5'h01;
            end
        end
    end

    // per-cell exit flags
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            uv_exit_status_r <= '0;
        end else if (ce_in) begin
            if (mode_write) begin
                uv_exit_status_r <= '0;
            end else if (checking && started_r) begin
                uv_exit_status_r <= uv_exit_status_r
                    | (balance_switch_enable_r & ~checkable);
                if (acc_we && (!filter_init_on_entry || settle_cnt_r >= SETTLE_SAMPLES)
                        && acc_new <= uv_threshold_r && 32'(sample_cell_r) < CELLS) begin
                    uv_exit_status_r[sample_cell_r] <= 1'b1;
                end
            end
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            rdata_r <= 32'h0000_0000;
            if (rd_in) begin
                unique case (addr_in)
                    ADDR_CTRL:    rdata_r <= ctrl_r;
                    ADDR_THR:     rdata_r <= 32'({threshold_from_lowest_cell_r, 1'b0, uv_threshold_r});
                    ADDR_UVSTAT:  rdata_r <= 32'(uv_exit_status_r);
                    ADDR_SWEN:    rdata_r <= 32'(balance_switch_enable_r);
                    ADDR_CELLCFG: rdata_r <= 32'(cell_measure_enable_r) | (32'(polarity_r) << CELLCFG_POL_LSB);
                    ADDR_SCAN:    rdata_r <= scan_control_r;
                    ADDR_DLY:     rdata_r <= 32'(calibration_interval_r);
                    ADDR_STATUS:  rdata_r <= {29'h0, all_cells_done_out, active, rejected_write_alert_r};
                    default:      rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign rdata_out = rdata_r;

    // exit cell switch stays off
    sw_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        uv_exit_status_r[0] |-> !switch_on_out[0]) else $error("exited cell switch on");
    // mode write clears status
    uv_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_write |=> uv_exit_status_r == '0) else $error("status not cleared");
    // no measurement when measure enable is 0b0x
    no_meas_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !balance_measure_enable[1] |-> !adc_start_out && !cal_start_out) else $error("measurement while off");
    // forced scan parameters
    forced_scan_a: assert property (@(posedge clk_in) disable iff (rst_in)
        measuring |-> oversample_count_out == OVS_16X && scan_order_mode_out == SCAN_PYRAMID)
        else $error("scan not forced");
    // rejected scan write
    scan_reject_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && wr_in && addr_in == ADDR_SCAN && active |=> rejected_write_alert_r
        && scan_control_r == $past(scan_control_r)) else $error("scan write accepted");
    // all done all off
    all_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        all_cells_done_out |-> switch_on_out == '0) else $error("switches on after done");
    // discharge never checks
    discharge_check_a: assert property (@(posedge clk_in) disable iff (rst_in)
        balance_mode_select == MODE_DISCHARGE |-> !checking) else $error("check in discharge");
    // measurement starts one cycle after pair
    pair_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && measuring && phase_r == PH_IDLE && pair_done_in && !mode_write
        |=> (adc_start_out || cal_start_out)) else $error("no measurement after pair");
    // direct threshold write
    thr_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && wr_in && addr_in == ADDR_THR && !wdata_in[THR_MIN_BIT]
        |=> uv_threshold_r == $past(wdata_in[THR_W-1:0])) else $error("threshold not loaded");
    // lowest-cell word becomes the threshold
    lowest_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && lowest_load_r && !(wr_in && addr_in == ADDR_THR)
        |=> uv_threshold_r == $past(acc_rd)) else $error("lowest cell not loaded");
    // no threshold exit before the settling samples are in
    settle_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_we && filter_init_on_entry && settle_cnt_r < SETTLE_SAMPLES && checkable[0]
        && sample_cell_r == 4'h0 && !mode_write && !uv_exit_status_r[0]
        |=> !uv_exit_status_r[0]) else $error("exit during settling");
    // calibration on the first cycle of a run
    cal_first_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && measuring && phase_r == PH_IDLE && pair_done_in && !mode_write
        && period != 6'h00 && cycle_cnt_r == 6'h00 |=> cal_start_out) else $error("first cycle not calibration");
    cov_cal_c:    cover property (@(posedge clk_in) cal_start_out);
    cov_exit_c:   cover property (@(posedge clk_in) uv_exit_status_r != '0);
    cov_done_c:   cover property (@(posedge clk_in) all_cells_done_out);
    cov_reject_c: cover property (@(posedge clk_in) rejected_write_alert_r);
endmodule // cell_balance_uv_measure_ctrl

// File: testbench/tb.sv
// self-checking bench for the balancing measurement controller
`timescale 1ns/1ps
module tb
    import uv_balance_pkg::*;
;
    logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0]  addr_in = 4'h0, adc_cell_in = 4'h0, low_in = 4'h0;
    logic [31:0] wdata_in = 32'h0, rdata_out, d;
    logic        pair_in = 1'b0, run_in = 1'b1, done_in = 1'b0;
    logic [13:0] data_in = 14'h0, sw_out;
    logic        adc_out, cal_out, fresh_out, fact_out, alert_out, all_out;
    logic [1:0]  ovs_out, ord_out;
    int          num_errors = 0, n_compared = 0, cyc = 0;
    // clock, 8 ns period
    always #4 clk_in = ~clk_in;
    cell_balance_uv_measure_ctrl i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pair_done_in(pair_in),
        .timer_running_in(run_in), .adc_start_out(adc_out), .cal_start_out(cal_out),
        .oversample_count_out(ovs_out), .scan_order_mode_out(ord_out), .use_fresh_cal_out(fresh_out),
        .use_factory_cal_out(fact_out), .adc_done_in(done_in), .adc_cell_in(adc_cell_in),
        .adc_data_in(data_in), .lowest_cell_index_in(low_in), .switch_on_out(sw_out),
        .rejected_write_alert_out(alert_out), .all_cells_done_out(all_out));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a; wdata_in <= v; wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // read, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a; rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // pair finished, request expected in the next cycle
    task automatic pair(input logic ea, input logic ec);
        @(posedge clk_in);
        pair_in <= 1'b1;
        @(posedge clk_in);
        pair_in <= 1'b0;
        #1 chk({adc_out, cal_out}, {ea, ec});
    endtask
    task automatic adc(input logic [3:0] c, input logic [13:0] v);
        @(posedge clk_in);
        done_in <= 1'b1; adc_cell_in <= c; data_in <= v;
        @(posedge clk_in);
        done_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic t_reset();
        rd(ADDR_THR); chk(d, 32'h0);
        rd(ADDR_UVSTAT); chk(d, 32'h0);
        rd(4'h9); chk(d, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_threshold();
        wr(ADDR_THR, 32'h0000_3FFF);
        rd(ADDR_THR); chk(d, 32'h0000_3FFF);
        wr(ADDR_THR, 32'h0000_1000);
        rd(ADDR_THR); chk(d, 32'h0000_1000);
        $display("test threshold done");
    endtask
    // scan lock, forced scan, unmeasurable cell, settling and exit
    task automatic t_uv_exit();
        wr(ADDR_SCAN, 32'h0000_0700);
        wr(ADDR_SWEN, 32'h0000_0003);
        wr(ADDR_CELLCFG, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0074);
        repeat (3) @(posedge clk_in);
        #1 chk({ovs_out, ord_out}, {OVS_16X, SCAN_PYRAMID});
        wr(ADDR_SCAN, 32'h0000_0003);
        rd(ADDR_SCAN); chk(d, 32'h0000_0700);
        rd(ADDR_STATUS); chk(d[1:0], 2'h3);
        chk(alert_out, 1'b1);
        rd(ADDR_UVSTAT); chk(d, 32'h2);
        chk(sw_out, 14'h0001);
        for (int i = 1; i <= 17; i++) begin
            pair(1'b1, 1'b0);
            adc(4'h0, 14'h0100);
            if (i == 16) begin
                rd(ADDR_UVSTAT); chk(d, 32'h2);
            end
        end
        rd(ADDR_UVSTAT); chk(d, 32'h3);
        chk({sw_out, all_out}, {14'h0, 1'b1});
        wr(ADDR_STATUS, 32'h1);
        #1 chk(alert_out, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0034);
        rd(ADDR_UVSTAT); chk(d[0], 1'b0);
        chk(sw_out[0], 1'b1);
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_UVSTAT); chk(d, 32'h0);
        $display("test uv exit done");
    endtask
    // measurement off, a mode that ignores the field, discharge without checks
    task automatic t_no_meas();
        wr(ADDR_CTRL, 32'h0000_0014);
        repeat (2) @(posedge clk_in);
        #1 chk({fresh_out, fact_out}, 2'b01);
        chk({ovs_out, ord_out}, 4'h0);
        pair(1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0032);
        repeat (2) @(posedge clk_in);
        pair(1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0033);
        repeat (3) @(posedge clk_in);
        #1 chk(sw_out, 14'h0003);
        pair(1'b1, 1'b0);
        adc(4'h0, 14'h0100);
        rd(ADDR_UVSTAT); chk(d, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        $display("test no measurement done");
    endtask
    // calibration every second and every twelfth cycle, filter continuation
    task automatic t_cal();
        wr(ADDR_DLY, 32'h1);
        wr(ADDR_CTRL, 32'h0000_00A4);
        repeat (2) @(posedge clk_in);
        #1 chk({fresh_out, fact_out}, 2'b10);
        for (int i = 0; i < 4; i++) begin
            pair(i[0], ~i[0]);
            adc(4'h0, 14'h0900);
        end
        wr(ADDR_THR, 32'h0000_8ABC);
        repeat (2) @(posedge clk_in);
        rd(ADDR_THR); chk(d, 32'h0000_82E0);
        wr(ADDR_DLY, 32'h4);
        wr(ADDR_CTRL, 32'h0000_00A4);
        for (int i = 0; i < 13; i++) begin
            pair(i % 12 != 0, i % 12 == 0);
            adc(4'h0, 14'h0900);
        end
        wr(ADDR_CTRL, 32'h0);
        $display("test calibration done");
    endtask
    // cycle ceiling against a hang
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 5000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_threshold();
        t_uv_exit();
        t_no_meas();
        t_cal();
        final_report();
    end
endmodule // tb
